/* core/cispio_top.sv */
/*
  In-system programming and I/O control: serial test port, staged
  programming of the configuration store, routing-bus selection into a
  logic block group, global output enables and per-pin buffer control.
  Assumes an APB master on core_clk; test port and pins are asynchronous.
*/
// Function
// RQ1: all inputs, pins, macrocells drive routing bus
// RQ2: bus signals enter group through gated AND
// RQ3: pin buffer control: global enable, low, high
// RQ4: six or ten global output enables, selectable
// RQ5: low tri-states pin, high always drives
// RQ6: pin and macrocell feedback are separate
// RQ7: programming tri-states pins with weak pull-ups
// RQ8: completion flag last; pins idle until set
// RQ9: serial shift in, read data shifted out
// RQ10: programmer runs six stages, verify four
// RQ11: entry stage takes 1 ms
// RQ12: programmer checks identity before program or verify
// RQ13: bulk erase is one 100 ms pulse
// RQ14: per address: shift address, data, pulse
// RQ15: per address: address, read pulse, shift out
// RQ16: exit stage takes 1 ms
// RQ17: programmer budgets pulses plus shift cycles
// RQ18: stages strictly ordered, no overlap with pulses
// RQ19: after exit, pins regain configured enables
// RQ20: group takes 36 bus inputs plus controls
`timescale 1ns/1ns
`default_nettype none
`include "cispio_params.svh"

module cispio_top #(
  parameter int NUM_IO    = 16,
  parameter int NUM_MC    = 16,
  parameter int NUM_GOE   = 6,
  parameter int ENTER_CYC = `CISPIO_ENTER_US * `CISPIO_CLK_MHZ,
  parameter int EXIT_CYC  = `CISPIO_EXIT_US * `CISPIO_CLK_MHZ,
  parameter int ERASE_CYC = `CISPIO_ERASE_US * `CISPIO_CLK_MHZ,
  parameter int PROG_CYC  = `CISPIO_PROG_US * `CISPIO_CLK_MHZ,
  parameter logic [`CISPIO_ID_W-1:0] ID_CODE = `CISPIO_ID_CODE // arbitrary value
) (
  input  wire logic                           core_clk,
  input  wire logic                           rstn,
  input  wire cispio_pkg::cispio_apb_req_t    apbReq,
  output logic [31:0]                         prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire cispio_pkg::cispio_jtag_t       jtag,
  output logic                                tdo,
  output logic                                tdoOe,
  input  wire logic [`CISPIO_DED_W-1:0]       dedIn,
  input  wire logic [NUM_IO-1:0]              ioIn,
  output logic [NUM_IO-1:0]                   ioOut,
  output logic [NUM_IO-1:0]                   ioOe,
  output logic [NUM_IO-1:0]                   ioPullup,
  input  wire logic [NUM_MC-1:0]              mcOut,
  output logic [`CISPIO_GROUP_IN-1:0]         groupIn,
  output logic [1:0]                          groupCtrl,
  output logic                                ispActive,
  output logic                                progDone
);
  import cispio_pkg::*;

  localparam int BUS_W     = `CISPIO_DED_W + NUM_IO + NUM_MC;
  localparam int GOE_WORDS = (NUM_GOE + `CISPIO_GOE_PER_WORD - 1) / `CISPIO_GOE_PER_WORD;
  localparam int DEPTH     = 32'(`CISPIO_PIN_ADDR) + NUM_IO + 1;
  localparam int DONE_IDX  = DEPTH - 1;
  localparam int READ_CYC  = (`CISPIO_READ_NS + `CISPIO_CLK_NS - 1) / `CISPIO_CLK_NS;
  localparam int AW        = `CISPIO_ADDR_W;
  localparam int DW        = `CISPIO_DR_W;

  // reset release and pin synchronisers
  logic rstS1_reg, rstS2_reg, rstnInt;
  cispio_jtag_t jtagS1_reg, jtagS2_reg;
  logic tckPrev_reg, tckRise, tckFall;
  logic [NUM_IO-1:0] ioS1_reg, ioS2_reg;
  logic [`CISPIO_DED_W-1:0] dedS1_reg, dedS2_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstS1_reg <= 1'b0;
      rstS2_reg <= 1'b0;
    end else begin
      rstS1_reg <= 1'b1;
      rstS2_reg <= rstS1_reg;
    end
  end
  assign rstnInt = rstS2_reg;

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      jtagS1_reg  <= '0;
      jtagS2_reg  <= '0;
      tckPrev_reg <= 1'b0;
      ioS1_reg    <= '0;
      ioS2_reg    <= '0;
      dedS1_reg   <= '0;
      dedS2_reg   <= '0;
    end else begin
      jtagS1_reg  <= jtag;
      jtagS2_reg  <= jtagS1_reg;
      tckPrev_reg <= jtagS2_reg.tck;
      ioS1_reg    <= ioIn;
      ioS2_reg    <= ioS1_reg;
      dedS1_reg   <= dedIn;
      dedS2_reg   <= dedS1_reg;
    end
  end
  assign tckRise = jtagS2_reg.tck & ~tckPrev_reg;
  assign tckFall = ~jtagS2_reg.tck & tckPrev_reg;

  // registers and state
  logic [31:0]           ctrl_reg;
  logic [AW-1:0]         cfgAddr_reg;
  cispio_tap_t           tap_reg, tapNext;
  logic [`CISPIO_IR_W-1:0] ir_reg, irShift_reg;
  logic [DW-1:0]         drShift_reg, readLatch_reg, progData_reg;
  logic                  bypass_reg;
  logic [AW-1:0]         addr_reg;
  cispio_stage_t         stage_reg;
  logic [31:0]           cnt_reg;
  logic [DW-1:0]         cfgMem_reg [DEPTH];
  logic                  jtagEn, updIr, updDr, cntEnd, drInstr;

  assign jtagEn  = ctrl_reg[0];
  assign updIr   = tckRise & (tap_reg == UPD_IR);
  assign updDr   = tckRise & (tap_reg == UPD_DR);
  assign cntEnd  = (cnt_reg == 32'h0000_0001);
  assign drInstr = (ir_reg == `CISPIO_IR_IDCODE) | (ir_reg == `CISPIO_IR_ADDR) |
                   (ir_reg == `CISPIO_IR_PROG) | (ir_reg == `CISPIO_IR_VERIFY);

  always_comb begin
    unique case (tap_reg)
      TEST_RESET: tapNext = jtagS2_reg.tms ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   tapNext = jtagS2_reg.tms ? SEL_DR : RUN_IDLE;
      SEL_DR:     tapNext = jtagS2_reg.tms ? SEL_IR : CAP_DR;
      CAP_DR:     tapNext = jtagS2_reg.tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   tapNext = jtagS2_reg.tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   tapNext = jtagS2_reg.tms ? UPD_DR : PAUSE_DR;
      PAUSE_DR:   tapNext = jtagS2_reg.tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   tapNext = jtagS2_reg.tms ? UPD_DR : SHIFT_DR;
      UPD_DR:     tapNext = jtagS2_reg.tms ? SEL_DR : RUN_IDLE;
      SEL_IR:     tapNext = jtagS2_reg.tms ? TEST_RESET : CAP_IR;
      CAP_IR:     tapNext = jtagS2_reg.tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   tapNext = jtagS2_reg.tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   tapNext = jtagS2_reg.tms ? UPD_IR : PAUSE_IR;
      PAUSE_IR:   tapNext = jtagS2_reg.tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   tapNext = jtagS2_reg.tms ? UPD_IR : SHIFT_IR;
      UPD_IR:     tapNext = jtagS2_reg.tms ? SEL_DR : RUN_IDLE;
    endcase
  end

  // test port controller; disabled port stays in reset
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt)
      tap_reg <= TEST_RESET;
    else if (!jtagEn)
      tap_reg <= TEST_RESET;
    else if (tckRise)
      tap_reg <= tapNext;
  end

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      irShift_reg <= '0;
      ir_reg      <= `CISPIO_IR_IDCODE;
    end else if (tap_reg == TEST_RESET) begin
      ir_reg <= `CISPIO_IR_IDCODE;
    end else if (tckRise) begin
      unique case (tap_reg)
        CAP_IR:   irShift_reg <= `CISPIO_IR_CAPTURE;
        SHIFT_IR: irShift_reg <= {jtagS2_reg.tdi, irShift_reg[`CISPIO_IR_W-1:1]}; // RQ9
        UPD_IR:   ir_reg <= irShift_reg;
        default:  ir_reg <= ir_reg;
      endcase
    end
  end

  // data register: identity, address, data and read-back share one path
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      drShift_reg <= '0;
      bypass_reg  <= 1'b0;
    end else if (tckRise && tap_reg == CAP_DR) begin
      bypass_reg <= 1'b0;
      if (ir_reg == `CISPIO_IR_IDCODE)
        drShift_reg <= DW'(ID_CODE);
      else if (ir_reg == `CISPIO_IR_VERIFY)
        drShift_reg <= readLatch_reg; // RQ15
      else
        drShift_reg <= '0;
    end else if (tckRise && tap_reg == SHIFT_DR) begin
      drShift_reg <= {jtagS2_reg.tdi, drShift_reg[DW-1:1]}; // RQ9
      bypass_reg  <= jtagS2_reg.tdi;
    end
  end

  // output changes on the falling test clock, as the far end samples on rising
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0;
    end else if (tckFall) begin
      tdoOe <= (tap_reg == SHIFT_IR) | (tap_reg == SHIFT_DR);
      if (tap_reg == SHIFT_IR)
        tdo <= irShift_reg[0];
      else
        tdo <= drInstr ? drShift_reg[0] : bypass_reg; // RQ9 RQ15
    end
  end

  // programming stages; commands arriving during a pulse are dropped
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      stage_reg    <= ST_USER;
      cnt_reg      <= '0;
      progData_reg <= '0;
    end else begin
      unique case (stage_reg)
        ST_USER: if (updIr && irShift_reg == `CISPIO_IR_ENTER) begin
          stage_reg <= ST_ENTERING;
          cnt_reg   <= 32'(ENTER_CYC); // RQ11
        end
        ST_IDLE: if (updIr && irShift_reg == `CISPIO_IR_ERASE) begin
          stage_reg <= ST_ERASING;
          cnt_reg   <= 32'(ERASE_CYC); // RQ13
        end else if (updIr && irShift_reg == `CISPIO_IR_VERIFY) begin
          stage_reg <= ST_READING;
          cnt_reg   <= 32'(READ_CYC); // RQ15
        end else if (updIr && irShift_reg == `CISPIO_IR_EXIT) begin
          stage_reg <= ST_EXITING;
          cnt_reg   <= 32'(EXIT_CYC); // RQ16
        end else if (updDr && ir_reg == `CISPIO_IR_PROG) begin
          stage_reg    <= ST_PROGRAMMING;
          cnt_reg      <= 32'(PROG_CYC); // RQ14
          progData_reg <= drShift_reg;
        end
        default: if (cntEnd) begin // RQ18
          stage_reg <= (stage_reg == ST_EXITING) ? ST_USER : ST_IDLE; // RQ19
          cnt_reg   <= '0;
        end else begin
          cnt_reg <= cnt_reg - 32'h0000_0001;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt)
      addr_reg <= '0;
    else if (updDr && ir_reg == `CISPIO_IR_ADDR && stage_reg == ST_IDLE)
      addr_reg <= drShift_reg[AW-1:0]; // RQ14 RQ15
  end

  // store powers up erased; the completion flag lives in the last word
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      for (int w = 0; w < DEPTH; w++)
        cfgMem_reg[w] <= '0;
      readLatch_reg <= '0;
    end else if (cntEnd && stage_reg == ST_ERASING) begin
      for (int w = 0; w < DEPTH; w++)
        cfgMem_reg[w] <= '0; // RQ13 RQ8
    end else if (cntEnd && stage_reg == ST_PROGRAMMING && 32'(addr_reg) < DEPTH) begin
      cfgMem_reg[addr_reg] <= progData_reg; // RQ14 RQ8
    end else if (cntEnd && stage_reg == ST_READING) begin
      readLatch_reg <= (32'(addr_reg) < DEPTH) ? cfgMem_reg[addr_reg] : '0; // RQ15
    end
  end

  // routing bus, group input gating and global output enables
  logic [BUS_W-1:0]   routeBus;
  logic [NUM_GOE-1:0] goeVec;
  logic [BUS_W-1:0]   goeSrc;

  assign routeBus = {dedS2_reg, ioS2_reg, mcOut}; // RQ1 RQ6
  assign goeSrc   = {~dedS2_reg[3], dedS2_reg[3], ~dedS2_reg[2], dedS2_reg[2],
                     ioS2_reg, mcOut}; // RQ4

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      groupIn   <= '0;
      groupCtrl <= '0;
      ispActive <= 1'b0;
      progDone  <= 1'b0;
    end else begin
      groupIn   <= `CISPIO_GROUP_IN'(routeBus) & cfgMem_reg[`CISPIO_ROUTE_ADDR]; // RQ2 RQ20
      groupCtrl <= dedS2_reg[1:0]; // RQ20
      ispActive <= (stage_reg != ST_USER); // RQ7
      progDone  <= cfgMem_reg[DONE_IDX][0]; // RQ8
    end
  end

  generate
    for (genvar g = 0; g < NUM_GOE; g++) begin : g_goe
      localparam int WI = 32'(`CISPIO_GOE_ADDR) + g / `CISPIO_GOE_PER_WORD;
      localparam int FI = (g % `CISPIO_GOE_PER_WORD) * `CISPIO_GOE_SEL_W;
      logic [`CISPIO_GOE_SEL_W-1:0] sel;
      assign sel       = cfgMem_reg[WI][FI +: `CISPIO_GOE_SEL_W];
      assign goeVec[g] = (32'(sel) < BUS_W) ? goeSrc[sel] : 1'b0; // RQ4
    end
    for (genvar p = 0; p < NUM_IO; p++) begin : g_pin
      localparam int PI = 32'(`CISPIO_PIN_ADDR) + p;
      cispio_pin_ctrl #(.NUM_GOE(NUM_GOE)) u_pin (
        .clk       (core_clk),
        .rstn      (rstnInt),
        .mode      (cfgMem_reg[PI][1:0]),
        .goeSel    (cfgMem_reg[PI][`CISPIO_PIN_IDX_W+1:2]),
        .goeVec    (goeVec),
        .dout      (mcOut[p % NUM_MC]),
        .ispActive (stage_reg != ST_USER), // RQ7
        .progDone  (cfgMem_reg[DONE_IDX][0]), // RQ8
        .pinOut    (ioOut[p]),
        .pinOe     (ioOe[p]),
        .pullEn    (ioPullup[p])
      );
    end
  endgenerate

  // APB slave: no wait state, answer registered
  logic apbSetup, apbDone, apbHit;
  logic [31:0] rdMux;

  assign apbSetup = apbReq.psel & ~apbReq.penable & ~pready;
  assign apbDone  = apbReq.psel & apbReq.penable & pready;

  always_comb begin
    apbHit = 1'b1;
    rdMux  = '0;
    unique case (apbReq.paddr)
      `CISPIO_CTRL_OFF:    rdMux = ctrl_reg;
      `CISPIO_STATUS_OFF:  rdMux = {20'h0_0000, ir_reg, 3'h0, progDone, ispActive, stage_reg};
      `CISPIO_CFGADDR_OFF: rdMux = 32'(cfgAddr_reg);
      `CISPIO_CFGLO_OFF:   rdMux = (32'(cfgAddr_reg) < DEPTH) ? cfgMem_reg[cfgAddr_reg][31:0] : '0;
      `CISPIO_CFGHI_OFF:   rdMux = (32'(cfgAddr_reg) < DEPTH) ? 32'(cfgMem_reg[cfgAddr_reg][DW-1:32]) : '0;
      default:             apbHit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~apbHit;
      prdata  <= (apbSetup && !apbReq.pwrite) ? rdMux : '0;
    end
  end

  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      ctrl_reg    <= `CISPIO_CTRL_RST;
      cfgAddr_reg <= '0;
    end else if (apbDone && apbReq.pwrite && !pslverr) begin
      if (apbReq.paddr == `CISPIO_CTRL_OFF)
        ctrl_reg <= {31'h0000_0000, apbReq.pwdata[0]};
      if (apbReq.paddr == `CISPIO_CFGADDR_OFF)
        cfgAddr_reg <= apbReq.pwdata[AW-1:0];
    end
  end

endmodule : cispio_top
`default_nettype wire

/* core/cispio_params.svh */
/*
  Constants of the in-system programming and I/O control block: register
  offsets, instruction codes, configuration word map and pulse times.
  Assumes it is included by bare name from core/ and testbench/ files.
*/
`ifndef CISPIO_PARAMS_SVH
`define CISPIO_PARAMS_SVH

// clock rate and documented waits
`define CISPIO_CLK_MHZ      100
`define CISPIO_ENTER_US     1000
`define CISPIO_EXIT_US      1000
`define CISPIO_ERASE_US     100000
`define CISPIO_PROG_US      1000
`define CISPIO_READ_NS      100
`define CISPIO_CLK_NS       10

// instruction register
`define CISPIO_IR_W         4
`define CISPIO_IR_CAPTURE   4'h1
`define CISPIO_IR_IDCODE    4'h1
`define CISPIO_IR_ENTER     4'h2
`define CISPIO_IR_ERASE     4'h3
`define CISPIO_IR_ADDR      4'h4
`define CISPIO_IR_PROG      4'h5
`define CISPIO_IR_VERIFY    4'h6
`define CISPIO_IR_EXIT      4'h7

// data path and configuration word map
`define CISPIO_DR_W         36
`define CISPIO_ADDR_W       5
`define CISPIO_ROUTE_ADDR   5'h00
`define CISPIO_GOE_ADDR     5'h01
`define CISPIO_PIN_ADDR     5'h03
`define CISPIO_GOE_SEL_W    6
`define CISPIO_GOE_PER_WORD 6
`define CISPIO_PIN_IDX_W    3
`define CISPIO_GROUP_IN     36
`define CISPIO_DED_W        4
`define CISPIO_ID_W         32
`define CISPIO_ID_CODE      32'h0000_5A5B

// per-pin buffer control modes
`define CISPIO_MODE_OFF     2'h0
`define CISPIO_MODE_ON      2'h1
`define CISPIO_MODE_GOE     2'h2

// APB register offsets
`define CISPIO_CTRL_OFF     12'h000
`define CISPIO_STATUS_OFF   12'h004
`define CISPIO_CFGADDR_OFF  12'h008
`define CISPIO_CFGLO_OFF    12'h00C
`define CISPIO_CFGHI_OFF    12'h010
`define CISPIO_CTRL_RST     32'h0000_0001

`endif

/* core/cispio_pkg.sv */
/*
  Types of the in-system programming and I/O control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cispio_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cispio_apb_req_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } cispio_jtag_t;

  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } cispio_tap_t;

  typedef enum logic [2:0] {
    ST_USER, ST_ENTERING, ST_IDLE, ST_ERASING, ST_PROGRAMMING, ST_READING, ST_EXITING
  } cispio_stage_t;

endpackage : cispio_pkg

/* core/cispio_pin_ctrl.sv */
/*
  One I/O pin's buffer control: picks constant low, constant high or one
  global output enable, and overrides it while programming is active or
  the configuration is incomplete. Assumes inputs on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cispio_params.svh"

module cispio_pin_ctrl #(
  parameter int NUM_GOE = 6
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [1:0]                  mode,
  input  wire logic [`CISPIO_PIN_IDX_W-1:0] goeSel,
  input  wire logic [NUM_GOE-1:0]          goeVec,
  input  wire logic                        dout,
  input  wire logic                        ispActive,
  input  wire logic                        progDone,
  output logic                             pinOut,
  output logic                             pinOe,
  output logic                             pullEn
);
  logic modeOe;

  always_comb begin
    unique case (mode)
      `CISPIO_MODE_ON:  modeOe = 1'b1; // RQ3 RQ5
      `CISPIO_MODE_GOE: modeOe = (32'(goeSel) < NUM_GOE) ? goeVec[goeSel] : 1'b0; // RQ3
      default:          modeOe = 1'b0; // RQ5
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinOe  <= 1'b0;
      pinOut <= 1'b0;
      pullEn <= 1'b0;
    end else begin
      pinOe  <= modeOe & progDone & ~ispActive; // RQ7 RQ8 RQ19
      pinOut <= dout;
      pullEn <= ispActive; // RQ7
    end
  end

endmodule : cispio_pin_ctrl
`default_nettype wire

/* testbench/cispio_top_props.sv */
/* Port checker for cispio_top: bus handshake, pin enables, pull-ups.
   Assumes a bind to cispio_top and one clock domain. */
`timescale 1ns/1ns
`default_nettype none
`include "cispio_params.svh"
module cispio_top_props #(
  parameter int NUM_IO = 16,
  parameter int NUM_MC = 16
) (
  input wire logic                         core_clk,
  input wire logic                         rstn,
  input wire cispio_pkg::cispio_apb_req_t  apbReq,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [`CISPIO_DED_W-1:0]     dedIn,
  input wire logic [NUM_IO-1:0]            ioOut,
  input wire logic [NUM_IO-1:0]            ioOe,
  input wire logic [NUM_IO-1:0]            ioPullup,
  input wire logic [NUM_MC-1:0]            mcOut,
  input wire logic [1:0]                   groupCtrl,
  input wire logic                         ispActive,
  input wire logic                         progDone
);
  import cispio_pkg::*;
  logic [2:0] upCnt;
  logic       up;
  // internal reset trails rstn by two edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      upCnt <= 3'h0;
    end else if (upCnt != 3'h7) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  assign up = (upCnt == 3'h7);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    apbReq.psel && !apbReq.penable;
  endsequence
  sequence s_ctrlStable;
    $stable(dedIn[1:0]) [*4];
  endsequence
  sequence s_ispHeld;
    ispActive && $past(ispActive) && $past(ispActive, 2);
  endsequence
  a_ready_after_setup: assert property (up ##0 s_setup |=> pready)
    else $error("no answer in the cycle after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_needs_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_isp_tristate: assert property (s_ispHeld |-> ioOe == '0)
    else $error("pin driven while programming");
  a_isp_pullup: assert property (s_ispHeld |-> &ioPullup)
    else $error("pull-up missing while programming");
  a_flag_gates_oe: assert property (!progDone && !$past(progDone) && !$past(progDone, 2)
    |-> ioOe == '0)
    else $error("pin driven before completion flag");
  a_feedback_apart: assert property (up |-> ioOut == $past(mcOut))
    else $error("pin drive does not follow macrocell");
  a_ctrl_synced: assert property (up ##0 s_ctrlStable |-> groupCtrl == dedIn[1:0])
    else $error("group controls do not follow inputs");
endmodule : cispio_top_props
bind cispio_top cispio_top_props #(.NUM_IO(NUM_IO), .NUM_MC(NUM_MC)) u_cispio_top_props (
  .core_clk(core_clk), .rstn(rstn), .apbReq(apbReq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dedIn(dedIn), .ioOut(ioOut), .ioOe(ioOe), .ioPullup(ioPullup),
  .mcOut(mcOut), .groupCtrl(groupCtrl), .ispActive(ispActive), .progDone(progDone));
`default_nettype wire

/* testbench/cispio_jtag_prog.sv */
/* Behavioural programmer on the serial test port, LSB first.
   Assumes the test clock idles low between frames. */
`timescale 1ns/1ns
`default_nettype none
module cispio_jtag_prog (
  output var cispio_pkg::cispio_jtag_t jtag,
  input  wire logic                    tdo
);
  import cispio_pkg::*;
  localparam int HALF = 62;
  initial begin
    jtag = '0;
  end
  // one 125 ns period; tdo taken just before the rising edge
  task automatic tick(input logic m, input logic d, output logic s);
    jtag.tms = m;
    jtag.tdi = d;
    #HALF;
    s = tdo;
    jtag.tck = 1'b1;
    #(HALF + 1);
    jtag.tck = 1'b0;
  endtask : tick
  task automatic idle();
    logic s;
    tick(1'b0, 1'b0, s);
  endtask : idle
  // from idle: select, capture, n shifts, update, back to idle
  task automatic shift(input logic isIr, input int n, input logic [35:0] din,
                       output logic [35:0] dout);
    logic s;
    tick(1'b1, 1'b0, s);
    if (isIr) begin
      tick(1'b1, 1'b0, s);
    end
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], s);
      dout[i] = s;
    end
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask : shift
endmodule : cispio_jtag_prog
`default_nettype wire

/* testbench/cispio_tb_top.sv */
/* Bench for cispio_top: register access over APB, staged programming
   through cispio_jtag_prog, pin enables in user mode afterwards.
   Assumes cispio_top_props is bound to the design. */
`timescale 1ns/1ns
`default_nettype none
`include "cispio_params.svh"
module cispio_tb_top;
  import cispio_pkg::*;
  localparam logic [31:0] ID_CODE = 32'h0000_1234; // arbitrary value
  localparam logic [4:0]  PADDR [6] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06};
  localparam logic [35:0] PDATA [6] = '{36'hF_FFFF_FFFF, 36'h860, 36'h1, 36'h3, 36'h2, 36'h6};
  logic            core_clk, rstn, pready, pslverr, tdo, ispActive, progDone, err;
  cispio_apb_req_t apbReq;
  cispio_jtag_t    jtag;
  logic [31:0]     prdata, rd;
  logic [3:0]      dedIn;
  logic [15:0]     ioIn, ioOut, ioOe, ioPullup, mcOut;
  logic [35:0]     groupIn, q;
  logic [1:0]      groupCtrl;
  int              errors, checks_done;
  cispio_top #(.ENTER_CYC(60), .EXIT_CYC(60), .ERASE_CYC(80), .PROG_CYC(40),
    .ID_CODE(ID_CODE)) u_cispio_top (.core_clk(core_clk), .rstn(rstn), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .jtag(jtag), .tdo(tdo), .tdoOe(),
    .dedIn(dedIn), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .ioPullup(ioPullup),
    .mcOut(mcOut), .groupIn(groupIn), .groupCtrl(groupCtrl), .ispActive(ispActive),
    .progDone(progDone));
  cispio_jtag_prog u_cispio_jtag_prog (.jtag(jtag), .tdo(tdo));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    apbReq <= '{1'b1, 1'b0, w, a, wd};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("apb ready", 36'h1, {35'h0, pready});
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
  endtask : apb
  // busy stage must show first, then the settled stage within a bound
  task automatic stage(input logic [2:0] busy, input logic [2:0] done);
    int n;
    apb(1'b0, `CISPIO_STATUS_OFF, 32'h0);
    chk("busy stage", {33'h1, busy}, {32'h0, rd[3:0]});
    for (n = 0; n < 300 && rd[2:0] !== done; n++) begin
      apb(1'b0, `CISPIO_STATUS_OFF, 32'h0);
    end
    chk("end stage", {33'h0, done}, {33'h0, rd[2:0]});
  endtask : stage
  task automatic ir(input logic [3:0] c);
    u_cispio_jtag_prog.shift(1'b1, 4, {32'h0, c}, q);
  endtask : ir
  task automatic dr(input logic [35:0] d);
    u_cispio_jtag_prog.shift(1'b0, 36, d, q);
  endtask : dr
  task automatic prog(input logic [4:0] a, input logic [35:0] d);
    ir(`CISPIO_IR_ADDR);
    dr({31'h0, a});
    ir(`CISPIO_IR_PROG);
    dr(d);
    stage(3'h4, 3'h2);
  endtask : prog
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (80000) @(posedge core_clk);
    errors++;
    $display("MISMATCH watchdog expected end seen hang");
    conclude();
  end
  initial begin
    rstn = 1'b0;
    apbReq = '0;
    dedIn = 4'h0;
    ioIn = 16'h0;
    mcOut = 16'h0;
    errors = 0;
    checks_done = 0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("reset oe", 36'h0, {20'h0, ioOe});
    chk("reset flag", 36'h0, {35'h0, progDone});
    apb(1'b1, `CISPIO_CTRL_OFF, 32'hFFFF_FFFF);
    apb(1'b0, `CISPIO_CTRL_OFF, 32'h0);
    chk("ctrl", 36'h1, {4'h0, rd});
    apb(1'b0, `CISPIO_STATUS_OFF, 32'h0);
    chk("status", 36'h100, {4'h0, rd});
    apb(1'b1, 12'h0FC, 32'h5);
    chk("unmapped err", 36'h1, {35'h0, err});
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped data", 36'h0, {4'h0, rd});
    $display("test registers done");
    u_cispio_jtag_prog.idle();
    ir(`CISPIO_IR_ENTER);
    stage(3'h1, 3'h2);
    chk("isp pullups", 36'hFFFF, {20'h0, ioPullup});
    chk("isp oe", 36'h0, {20'h0, ioOe});
    ir(`CISPIO_IR_IDCODE);
    dr(36'h0);
    chk("id code", {4'h0, ID_CODE}, {4'h0, q[31:0]});
    ir(`CISPIO_IR_ERASE);
    stage(3'h3, 3'h2);
    chk("erased group", 36'h0, groupIn);
    for (int i = 0; i < 6; i++) begin
      prog(PADDR[i], PDATA[i]);
    end
    for (int i = 0; i < 6; i++) begin
      ir(`CISPIO_IR_ADDR);
      dr({31'h0, PADDR[i]});
      ir(`CISPIO_IR_VERIFY);
      dr(36'h0);
      chk("verify word", PDATA[i], q);
    end
    ir(`CISPIO_IR_EXIT);
    stage(3'h6, 3'h0);
    chk("no flag oe", 36'h0, {20'h0, ioOe});
    chk("no flag", 36'h0, {35'h0, progDone});
    $display("test program done");
    // flag written last, in its own session
    ir(`CISPIO_IR_ENTER);
    stage(3'h1, 3'h2);
    prog(5'h13, 36'h1);
    ir(`CISPIO_IR_EXIT);
    stage(3'h6, 3'h0);
    chk("flag set", 36'h1, {35'h0, progDone});
    chk("user pullups", 36'h0, {20'h0, ioPullup});
    dedIn <= 4'h4;
    mcOut <= 16'h0001;
    repeat (6) @(posedge core_clk);
    chk("oe enable high", 36'h5, {20'h0, ioOe});
    chk("pin out", 36'h1, {20'h0, ioOut});
    dedIn <= 4'h0;
    repeat (6) @(posedge core_clk);
    chk("oe enable low", 36'h9, {20'h0, ioOe});
    dedIn <= 4'hF;
    ioIn <= 16'hFFFF;
    mcOut <= 16'hFFFF;
    repeat (6) @(posedge core_clk);
    chk("group inputs", 36'hF_FFFF_FFFF, groupIn);
    chk("group ctrl", 36'h3, {34'h0, groupCtrl});
    chk("input pin out", 36'hFFFF, {20'h0, ioOut});
    apb(1'b1, `CISPIO_CFGADDR_OFF, 32'h1);
    apb(1'b0, `CISPIO_CFGLO_OFF, 32'h0);
    chk("cfg word", 36'h860, {4'h0, rd});
    $display("test user mode done");
    conclude();
  end
endmodule : cispio_tb_top
`default_nettype wire
